// [shared/fpc_pkg.sv]
// Constants, field layouts and carrier types of the front-panel console.
// Assumes one 100 MHz processor clock shared with the core and the register bus.
package fpc_pkg;

   // Clock and switch debounce timing.
   localparam int unsigned CLK_MHZ             = 100;
   localparam int unsigned DEBOUNCE_TIME_US    = 5000;
   localparam int unsigned DEBOUNCE_CYCLES_DEF = DEBOUNCE_TIME_US * CLK_MHZ;
   localparam int          DB_CNT_W            = 20;

   // Momentary and held panel switches, one debouncer each.
   localparam int NUM_KEYS      = 8;
   localparam int KEY_ADDR_LOAD = 0;
   localparam int KEY_EXTD_LOAD = 1;
   localparam int KEY_CLEAR     = 2;
   localparam int KEY_CONT      = 3;
   localparam int KEY_EXAM      = 4;
   localparam int KEY_HALT      = 5;
   localparam int KEY_STEP      = 6;
   localparam int KEY_DEP       = 7;

   // Register map, byte addresses on the AXI4-Lite slave.
   localparam int          AXI_ADDR_W  = 8;
   localparam logic [7:0]  OFS_SWITCH  = 8'h00;
   localparam logic [7:0]  OFS_SELECT  = 8'h04;
   localparam logic [7:0]  OFS_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_CONSOLE = 8'h0c;
   localparam logic [7:0]  OFS_LAMPS   = 8'h10;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Word bits are numbered from the most significant end: bit n sits at index 11-n.
   localparam int ST_LINK    = 11;
   localparam int ST_GTF     = 10;
   localparam int ST_IRQ     = 9;
   localparam int ST_INHIBIT = 8;
   localparam int ST_IE      = 7;
   localparam int ST_USER    = 6;
   localparam int FLD_IF_LSB = 3;
   localparam int FLD_DF_LSB = 0;

   // Instruction decode for the user-mode privilege check.
   localparam logic [2:0] OP_IOT     = 3'h6;
   localparam logic [2:0] OP_OPERATE = 3'h7;
   localparam int         OP_LSB     = 9;
   localparam int         GRP2_BIT   = 8;
   localparam int         GRP3_BIT   = 0;
   localparam int         OSR_BIT    = 2;
   localparam int         HLT_BIT    = 1;

   typedef enum logic [2:0] {
      SEL_BUS    = 3'b000,
      SEL_MQ     = 3'b001,
      SEL_MD     = 3'b010,
      SEL_AC     = 3'b011,
      SEL_STATUS = 3'b100,
      SEL_STATE  = 3'b101
   } fpc_sel_t;

   typedef enum logic [1:0] {
      MS_IDLE  = 2'b00,
      MS_READ  = 2'b01,
      MS_WRITE = 2'b10
   } fpc_mstate_t;

   // What the console sees of the core and the backplane.
   typedef struct packed {
      logic [11:0] data_bus;
      logic [11:0] multiplier_quotient;
      logic [11:0] memory_data_bus;
      logic [11:0] accumulator;
      logic [11:0] memory_address_bus;
      logic [2:0]  extended_field_bus;
      logic        link;
      logic        greater_than_flag;
      logic        int_request;
      logic        int_inhibit;
      logic        int_enable;
      logic        user_mode;
      logic        fetch_start;
      logic        time_state_one;
      logic        mem_done;
   } fpc_core_view_t;

   // What the console drives towards the core and memory.
   typedef struct packed {
      logic        initialize;
      logic        run;
      logic        mem_start;
      logic        force_fetch;
      logic [11:0] console_memory_address;
      logic [2:0]  instr_field;
      logic [2:0]  data_field;
      logic [11:0] memory_buffer;
      logic        mem_req;
      logic        mem_write;
      logic [11:0] mem_wdata;
      logic        pc_increment;
      logic        privileged_inhibit;
      logic        stop_at_ts1;
   } fpc_core_ctl_t;

endpackage

// [design/fpc_debounce.sv]
// Debouncer for one panel switch: a stable level and a one-cycle press pulse.
// Assumes the raw switch level is already synchronous to aclk.
module fpc_debounce
   import fpc_pkg::*;
#(
   parameter int unsigned CYCLES = DEBOUNCE_CYCLES_DEF
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic raw,
   output logic      level,
   output logic      press
);

   typedef struct packed {
      logic                level;
      logic                press;
      logic [DB_CNT_W-1:0] cnt;
   } fpc_db_state_t;

   fpc_db_state_t s;
   fpc_db_state_t next_s;

   // A change must hold for the whole debounce time before it is believed.
   always_comb
   begin
      next_s       = s;
      next_s.press = 1'b0;
      if (raw != s.level)
      begin
         if (s.cnt == DB_CNT_W'(CYCLES - 1))
         begin
            next_s.level = raw;
            next_s.press = raw;
            next_s.cnt   = '0;
         end
         else
         begin
            next_s.cnt = s.cnt + DB_CNT_W'(1);
         end
      end
      else
      begin
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;
      else if (ce)
         s <= next_s;
   end

   assign level = s.level;
   assign press = s.press;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_press_one_cycle: assert property (press |=> !press)
      else $error("press pulse lasted more than one cycle");

endmodule // fpc_debounce

// [design/fpc_console.sv]
// Front-panel console: manual operations, run control and lamp multiplexing.
// Assumes the core stops at its next fetch or TS1 when run drops, and answers mem_req with mem_done.
//
// What this block does
// - Address load copies switch value to console address and forces fetch next cycle.
// - Extended load puts switch bits 6-8 in instruction field, 9-11 in data field.
// - Clear emits initialize pulse zeroing accumulator, link, device flags, interrupt state.
// - Continue sets run and issues memory start from console address.
// - Examine reads memory at console address into buffer, then increments address and PC.
// - Deposit writes switch value to buffer and memory, then increments address and PC.
// - Halt clears run; processor stops at start of next fetch.
// - With halt held, each continue runs exactly one instruction.
// - Single step clears run; processor stops at TS1 of next machine cycle.
// - With single step held, each continue runs exactly one machine cycle.
// - Panel lock ignores all manual controls except switches, boot switch, run lamp.
// - Boot-request line released high when switch up, asserted when down.
// - Address lamps show field bus joined to address bus, fifteen bits.
// - Six-position selector: five positions choose the source of the twelve-bit display, the state position shows zero.
// - Status bits 0-5: link, greater-than, interrupt request, inhibit, enable, user mode.
// - Status bits 6-8 show instruction field, bits 9-11 data field.
// - In user mode, switch-OR, load-switches, I/O transfer and halt instructions are disabled.
// - Memory data display shows the memory data bus.
module fpc_console
   import fpc_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF
)
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic [NUM_KEYS-1:0]   keys_raw,
   input  wire logic                  panel_lock,
   input  wire logic                  boot_switch_down,
   input  wire logic                  boot_request_line_in,
   output logic                       boot_request_line_out,
   output logic                       boot_request_line_oe,
   input  wire fpc_core_view_t        core_in,
   output fpc_core_ctl_t              core_out,
   output logic                       run_lamp,
   output logic [14:0]                address_lamps,
   output logic [11:0]                data_lamps
);

   typedef struct packed {
      fpc_core_ctl_t ctl;
      logic [11:0]   sw;
      fpc_sel_t      sel;
      fpc_mstate_t   mst;
      logic          boot_drive;
      logic [14:0]   addr_lamps;
      logic [11:0]   data_lamps;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [1:0]    rresp;
      logic [31:0]   rdata;
   } fpc_state_t;

   fpc_state_t          s;
   fpc_state_t          next_s;
   logic [NUM_KEYS-1:0] key_level;
   logic [NUM_KEYS-1:0] key_press;
   logic [NUM_KEYS-1:0] cmd;
   logic                halt_held;
   logic                step_held;
   logic                wr_take;
   logic                rd_take;
   logic                privileged;
   logic [11:0]         status_word;

   for (genvar k = 0; k < NUM_KEYS; k++)
   begin : g_key
      fpc_debounce #(
         .CYCLES (DEBOUNCE_CYCLES)
      ) u_db (
         .aclk    (aclk),
         .aresetn (aresetn),
         .ce      (ce),
         .raw     (keys_raw[k]),
         .level   (key_level[k]),
         .press   (key_press[k])
      );
   end

   // The lock leaves the switch value and the boot switch alive, so a running program is safe.
   assign cmd       = panel_lock ? '0 : key_press;
   assign halt_held = key_level[KEY_HALT] && !panel_lock;
   assign step_held = key_level[KEY_STEP] && !panel_lock;

   // Address and data are taken together; a pending response blocks the next write.
   assign wr_take = ce && s_axi_awvalid && s_axi_wvalid && !s.bvalid;
   assign rd_take = ce && s_axi_arvalid && !s.rvalid;

   assign privileged = (core_in.memory_data_bus[11:OP_LSB] == OP_IOT)
                    || (core_in.memory_data_bus[11:OP_LSB] == OP_OPERATE
                        && core_in.memory_data_bus[GRP2_BIT]
                        && !core_in.memory_data_bus[GRP3_BIT]
                        && (core_in.memory_data_bus[OSR_BIT] || core_in.memory_data_bus[HLT_BIT]));

   always_comb
   begin
      status_word                                = '0;
      status_word[ST_LINK]                       = core_in.link;
      status_word[ST_GTF]                        = core_in.greater_than_flag;
      status_word[ST_IRQ]                        = core_in.int_request;
      status_word[ST_INHIBIT]                    = core_in.int_inhibit;
      status_word[ST_IE]                         = core_in.int_enable;
      status_word[ST_USER]                       = core_in.user_mode;
      status_word[FLD_IF_LSB +: 3]               = s.ctl.instr_field;
      status_word[FLD_DF_LSB +: 3]               = s.ctl.data_field;
   end

   always_comb
   begin
      next_s                        = s;
      next_s.ctl.initialize         = 1'b0;
      next_s.ctl.mem_start          = 1'b0;
      next_s.ctl.force_fetch        = 1'b0;
      next_s.ctl.pc_increment       = 1'b0;
      next_s.ctl.privileged_inhibit = core_in.user_mode && core_in.fetch_start && privileged;
      next_s.ctl.stop_at_ts1        = step_held;
      next_s.boot_drive             = boot_switch_down;

      if (cmd[KEY_ADDR_LOAD])
      begin
         next_s.ctl.console_memory_address = s.sw;
         next_s.ctl.force_fetch            = 1'b1;
      end
      if (cmd[KEY_EXTD_LOAD])
      begin
         next_s.ctl.instr_field = s.sw[FLD_IF_LSB +: 3];
         next_s.ctl.data_field  = s.sw[FLD_DF_LSB +: 3];
      end
      if (cmd[KEY_CLEAR])
         next_s.ctl.initialize = 1'b1;

      // The stop points: after one instruction with halt held, after one cycle with step held.
      if (cmd[KEY_HALT] || cmd[KEY_STEP])
         next_s.ctl.run = 1'b0;
      if (s.ctl.run && halt_held && core_in.fetch_start)
         next_s.ctl.run = 1'b0;
      if (s.ctl.run && step_held && core_in.time_state_one)
         next_s.ctl.run = 1'b0;

      // Continue wins over a stop in the same cycle; a press while a memory cycle is pending (mst not MS_IDLE) is dropped.
      if (cmd[KEY_CONT] && s.mst == MS_IDLE)
      begin
         next_s.ctl.run       = 1'b1;
         next_s.ctl.mem_start = 1'b1;
      end

      case (s.mst)
         MS_IDLE:
         begin
            if (cmd[KEY_EXAM] && !s.ctl.run)
            begin
               next_s.ctl.mem_req   = 1'b1;
               next_s.ctl.mem_write = 1'b0;
               next_s.mst           = MS_READ;
            end
            else if (cmd[KEY_DEP] && !s.ctl.run)
            begin
               next_s.ctl.memory_buffer = s.sw;
               next_s.ctl.mem_wdata     = s.sw;
               next_s.ctl.mem_req       = 1'b1;
               next_s.ctl.mem_write     = 1'b1;
               next_s.mst               = MS_WRITE;
            end
         end
         MS_READ, MS_WRITE:
         begin
            if (core_in.mem_done)
            begin
               if (s.mst == MS_READ)
                  next_s.ctl.memory_buffer = core_in.memory_data_bus;
               next_s.ctl.mem_req                = 1'b0;
               next_s.ctl.mem_write              = 1'b0;
               next_s.ctl.console_memory_address = s.ctl.console_memory_address + 12'h001;
               next_s.ctl.pc_increment           = 1'b1;
               next_s.mst                        = MS_IDLE;
            end
         end
         default:
         begin
            next_s.mst = MS_IDLE;
         end
      endcase

      next_s.addr_lamps = {core_in.extended_field_bus, core_in.memory_address_bus};
      case (s.sel)
         SEL_BUS:    next_s.data_lamps = core_in.data_bus;
         SEL_MQ:     next_s.data_lamps = core_in.multiplier_quotient;
         SEL_MD:     next_s.data_lamps = core_in.memory_data_bus;
         SEL_AC:     next_s.data_lamps = core_in.accumulator;
         SEL_STATUS: next_s.data_lamps = status_word;
         default:    next_s.data_lamps = 12'h000;
      endcase

      if (s.bvalid && s_axi_bready)
         next_s.bvalid = 1'b0;
      if (wr_take)
      begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         if (s_axi_awaddr == OFS_SWITCH)
         begin
            if (s_axi_wstrb[0])
               next_s.sw[7:0] = s_axi_wdata[7:0];
            if (s_axi_wstrb[1])
               next_s.sw[11:8] = s_axi_wdata[11:8];
         end
         else if (s_axi_awaddr == OFS_SELECT)
         begin
            if (s_axi_wstrb[0])
               next_s.sel = fpc_sel_t'(s_axi_wdata[2:0]);
         end
         else if (s_axi_awaddr != OFS_STATUS && s_axi_awaddr != OFS_CONSOLE && s_axi_awaddr != OFS_LAMPS)
            next_s.bresp = RESP_SLVERR;
      end

      if (s.rvalid && s_axi_rready)
         next_s.rvalid = 1'b0;
      if (rd_take)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         if (s_axi_araddr == OFS_SWITCH)
            next_s.rdata = {20'h00000, s.sw};
         else if (s_axi_araddr == OFS_SELECT)
            next_s.rdata = {29'h00000000, s.sel};
         else if (s_axi_araddr == OFS_STATUS)
            next_s.rdata = {26'h0000000, s.mst, boot_request_line_in, s.boot_drive, panel_lock, s.ctl.run};
         else if (s_axi_araddr == OFS_CONSOLE)
            next_s.rdata = {14'h0000, s.ctl.instr_field, s.ctl.data_field, s.ctl.console_memory_address};
         else if (s_axi_araddr == OFS_LAMPS)
            next_s.rdata = {5'h00, s.addr_lamps, s.data_lamps};
         else
         begin
            next_s.rdata = 32'h00000000;
            next_s.rresp = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;
      else if (ce)
         s <= next_s;
   end

   assign s_axi_awready         = wr_take;
   assign s_axi_wready          = wr_take;
   assign s_axi_bvalid          = s.bvalid;
   assign s_axi_bresp           = s.bresp;
   assign s_axi_arready         = rd_take;
   assign s_axi_rvalid          = s.rvalid;
   assign s_axi_rdata           = s.rdata;
   assign s_axi_rresp           = s.rresp;
   assign boot_request_line_out = 1'b0;
   assign boot_request_line_oe  = s.boot_drive;
   assign core_out              = s.ctl;
   assign run_lamp              = s.ctl.run;
   assign address_lamps         = s.addr_lamps;
   assign data_lamps            = s.data_lamps;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_addr_load_copy: assert property (ce && cmd[KEY_ADDR_LOAD] |=>
      core_out.force_fetch && core_out.console_memory_address == $past(s.sw))
      else $error("address load did not copy switches");
   a_extd_load_fields: assert property (ce && cmd[KEY_EXTD_LOAD] |=>
      {core_out.instr_field, core_out.data_field} == $past(s.sw[5:0]))
      else $error("field load wrong");
   a_clear_init_pulse: assert property (ce && cmd[KEY_CLEAR] |=> core_out.initialize)
      else $error("clear gave no initialize pulse");
   a_cont_starts_run: assert property (ce && cmd[KEY_CONT] && s.mst == MS_IDLE |=>
      core_out.run && core_out.mem_start)
      else $error("continue did not start");
   a_exam_read_incr: assert property (ce && s.mst == MS_READ && core_in.mem_done |=>
      core_out.pc_increment && core_out.memory_buffer == $past(core_in.memory_data_bus))
      else $error("examine did not latch and increment");
   a_dep_write_req: assert property (ce && cmd[KEY_DEP] && !cmd[KEY_EXAM] && s.mst == MS_IDLE && !s.ctl.run |=>
      core_out.mem_req && core_out.mem_write && core_out.mem_wdata == $past(s.sw))
      else $error("deposit did not request write");
   a_halt_clears_run: assert property (ce && cmd[KEY_HALT] && !cmd[KEY_CONT] |=> !core_out.run)
      else $error("halt left run set");
   a_halt_one_instr: assert property (ce && s.ctl.run && halt_held && core_in.fetch_start && !cmd[KEY_CONT]
      |=> !core_out.run)
      else $error("halt held did not stop after one instruction");
   a_step_one_cycle: assert property (ce && s.ctl.run && step_held && core_in.time_state_one && !cmd[KEY_CONT]
      |=> !core_out.run)
      else $error("step held did not stop after one cycle");
   a_lock_keeps_stop: assert property (ce && panel_lock && !s.ctl.run |=> !core_out.run)
      else $error("locked panel started the processor");
   a_boot_line_drive: assert property (ce && boot_switch_down |=> boot_request_line_oe && !boot_request_line_out)
      else $error("boot line not asserted");
   a_status_fields: assert property (ce && s.sel == SEL_STATUS |=>
      data_lamps[5:0] == {$past(s.ctl.instr_field), $past(s.ctl.data_field)} && data_lamps[ST_LINK] == $past(core_in.link))
      else $error("status word wrong");
   a_privileged_block: assert property (ce && core_in.user_mode && core_in.fetch_start && privileged
      |=> core_out.privileged_inhibit)
      else $error("privileged instruction not inhibited");

endmodule // fpc_console

// [tb/fpc_core_model.sv]
// Behavioural core and memory behind the console.
// Assumes one aclk domain; answers each memory request after two cycles.
module fpc_core_model
   import fpc_pkg::*;
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire fpc_core_ctl_t core_out,
   output fpc_core_view_t     core_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [11:0] mem [4096];
   logic [11:0] acc;
   logic [1:0]  wait_cnt;
   logic [2:0]  phase;
   logic        done;
   initial for (int i = 0; i < 4096; i++) mem[i] = ~i[11:0];
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acc <= 12'h789;
         wait_cnt <= 2'h0;
         phase <= 3'h0;
         done <= 1'b0;
      end
      else
      begin
         if (core_out.initialize) acc <= 12'h000;
         wait_cnt <= core_out.mem_req ? wait_cnt + 2'h1 : 2'h0;
         // The done pulse is only ever raised while the request still stands.
         done <= core_out.mem_req && wait_cnt == 2'h1;
         if (done && core_out.mem_write) mem[core_out.console_memory_address] <= core_out.mem_wdata;
         phase <= core_out.run ? phase + 3'h1 : 3'h0;
      end
   end
   always_comb
   begin
      core_in = '0;
      core_in.data_bus = 12'h123;
      core_in.multiplier_quotient = 12'h456;
      core_in.memory_data_bus = mem[core_out.console_memory_address];
      core_in.accumulator = acc;
      core_in.memory_address_bus = core_out.console_memory_address;
      core_in.extended_field_bus = core_out.instr_field;
      core_in.link = 1'b1;
      core_in.int_request = 1'b1;
      core_in.int_enable = 1'b1;
      core_in.fetch_start = core_out.run && phase == 3'h7;
      core_in.time_state_one = core_out.run && phase[1:0] == 2'h3;
      core_in.mem_done = done;
   end
endmodule // fpc_core_model

// [tb/front_panel_console_control_test.sv]
// Self-checking bench for the front-panel console.
// Assumes the core model above and a pulled-up boot line.
module front_panel_console_control_test;
   import fpc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 0, aresetn = 0, ce = 1, panel_lock = 0, boot_switch_down = 0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, run_lamp;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [7:0] keys_raw = '0;
   logic boot_request_line_in, boot_request_line_out, boot_request_line_oe;
   logic [14:0] address_lamps;
   logic [11:0] data_lamps;
   fpc_core_view_t core_in;
   fpc_core_ctl_t core_out;
   int n_fail = 0, n_compared = 0, n_init = 0, n_start = 0, n_pc = 0, n_ff = 0;
   localparam logic [11:0] EXP_ROW [6] = '{12'h123, 12'h456, 12'hfd3, 12'h789, 12'haab, 12'h000};
   localparam int HOLD_KEY [2] = '{KEY_HALT, KEY_STEP};
   fpc_console #(.DEBOUNCE_CYCLES(4)) u_dut (.*);
   fpc_core_model u_core (.*);
   assign boot_request_line_in = boot_request_line_oe ? boot_request_line_out : 1'b1;
   always #5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      n_init += core_out.initialize;
      n_start += core_out.mem_start;
      n_pc += core_out.pc_increment;
      n_ff += core_out.force_fetch;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      @(posedge aclk iff (s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 0;
      s_axi_wvalid <= 0;
      @(posedge aclk iff s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rdw(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      @(posedge aclk iff s_axi_arready);
      s_axi_arvalid <= 0;
      @(posedge aclk iff s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // Held well past the debounce time so a second pulse would show up in the counts.
   task automatic press(input int k);
      @(posedge aclk);
      keys_raw[k] <= 1;
      repeat (20) @(posedge aclk);
      keys_raw[k] <= 0;
      repeat (12) @(posedge aclk);
   endtask
   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      stop_test;
   end
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      check({run_lamp, boot_request_line_oe, data_lamps}, 0);
      wr(OFS_SWITCH, 32'h02b);
      press(KEY_EXTD_LOAD);
      check({core_out.instr_field, core_out.data_field}, 6'h2b);
      press(KEY_ADDR_LOAD);
      check({n_ff, core_out.console_memory_address}, {32'h1, 12'h02b});
      wr(OFS_SWITCH, 32'h5a5);
      press(KEY_DEP);
      check({u_core.mem[12'h02b], core_out.memory_buffer}, 24'h5a55a5);
      check(core_out.console_memory_address, 12'h02c);
      wr(OFS_SWITCH, 32'h02b);
      press(KEY_ADDR_LOAD);
      press(KEY_EXAM);
      check({core_out.memory_buffer, core_out.console_memory_address}, 24'h5a502c);
      check(n_pc, 2);
      rdw(OFS_SWITCH);
      check(rd, 32'h02b);
      rdw(8'h20);
      check({rd, rr}, {32'h0, RESP_SLVERR});
      wr(8'h20, 32'h0);
      check(rr, RESP_SLVERR);
      wr(OFS_STATUS, 32'h0);
      check(rr, RESP_OKAY);
      $display("memory test done");
      for (int i = 0; i < 6; i++)
      begin
         wr(OFS_SELECT, i);
         repeat (3) @(posedge aclk);
         check(data_lamps, EXP_ROW[i]);
      end
      check(address_lamps, {3'h5, 12'h02c});
      press(KEY_CLEAR);
      wr(OFS_SELECT, SEL_AC);
      repeat (3) @(posedge aclk);
      check({n_init, data_lamps}, {32'h1, 12'h000});
      $display("display test done");
      for (int j = 0; j < 2; j++)
      begin
         press(KEY_CONT);
         check(run_lamp, 1);
         keys_raw[HOLD_KEY[j]] <= 1;
         repeat (12) @(posedge aclk);
         check(run_lamp, 0);
         press(KEY_CONT);
         check({run_lamp, core_out.stop_at_ts1}, j);
         check(n_start, 2 * j + 2);
         keys_raw[HOLD_KEY[j]] <= 0;
         @(posedge aclk);
      end
      panel_lock <= 1;
      press(KEY_CONT);
      press(KEY_CLEAR);
      check({run_lamp, n_init}, 1);
      panel_lock <= 0;
      boot_switch_down <= 1;
      repeat (3) @(posedge aclk);
      check(boot_request_line_in, 0);
      boot_switch_down <= 0;
      repeat (3) @(posedge aclk);
      check(boot_request_line_in, 1);
      $display("run control test done");
      stop_test;
   end
endmodule // front_panel_console_control_test
